// ==== tb_top.sv ====
// Bench for the branch sync front end: registers, data path, sync search and lock, rescale
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk = 1'b0, srst = 1'b1, run = 1'b0, unanimous = 1'b1, max_over = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, bc_q;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
	logic [5:0] tap_depth;
	logic branch_clk, proc_inhibit, dec_reset, rescale_sub, sync_locked, bit_clk;
	logic [2:0] sample_in, pat_data, mon;
	logic [2:0] seq [0:2];
	logic [15:0] bit_count;
	logic [8:0] tab_s [0:2] = '{9'h1c5, 9'h0e6, 9'h070};
	logic [31:0] tab_c [0:2] = '{32'h0000_0007, 32'h0000_000f, 32'h0000_0012};
	logic [5:0] dep [0:3] = '{6'h10, 6'h16, 6'h1b, 6'h20};
	vbsf_pkg::vbsf_branch_t branch_out, exp_b;
	logic [vbsf_pkg::NUM_PAT-1:0][4:0] incr_corr;
	int n_errors = 0, total_checks = 0, n_br = 0, last_iv = 0, max_iv = 0, iv = 0, div = 3;
	assign pat_data = seq[bit_count % div];
	assign mon = {rescale_sub, sync_locked, dec_reset};
	always #5 core_clk = ~core_clk;
	vbsf_front_end vbsf_front_end_inst (.core_clk, .srst, .bit_clk, .sample_in, .unanimous,
		.max_over, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tap_depth, .branch_clk,
		.branch_out, .incr_corr, .proc_inhibit, .dec_reset, .rescale_sub, .sync_locked);
	vbsf_bitsync_model vbsf_bitsync_model_inst (.core_clk, .srst, .run, .pat_data, .bit_clk,
		.sample_in, .bit_count);
	// Branch rises counted, spacing kept in core cycles
	always @(posedge core_clk) begin
		bc_q <= branch_clk;
		iv <= iv + 1;
		if (iv > max_iv) max_iv <= iv;
		if (branch_clk && !bc_q) begin
			n_br <= n_br + 1;
			last_iv <= iv;
			iv <= 1;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic do_reset();
		run <= 1'b0;
		srst <= 1'b1;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
	endtask
	// Bounded wait for a design output, sampled once settled after each edge
	task automatic wait_hi(input int i, input int lim);
		repeat (lim) begin
			@(posedge core_clk);
			#1;
			if (mon[i] === 1'b1) break;
		end
		// A limit that runs out is counted as a mismatch
		chk(32'(mon[i] === 1'b1), 32'h1);
	endtask
	// Expected branch from the current samples, quantization and rate
	function automatic vbsf_pkg::vbsf_branch_t mk(input logic [1:0] q, input logic third);
		vbsf_pkg::vbsf_branch_t b;
		logic [2:0] x;
		for (int s = 0; s < 3; s++) begin
			x = seq[s][2] ? seq[s] : {1'b0, ~seq[s][1:0]};
			b.tru[s] = x;
			b.cmp[s] = ~x;
			if (q != 2'h0) begin
				b.tru[s][0] = 1'b1;
				b.cmp[s][0] = 1'b1;
			end
			if (q[1]) begin
				b.tru[s][1] = 1'b1;
				b.cmp[s][1] = 1'b1;
			end
			if (!third && s == 2) begin
				b.tru[s] = 3'h7;
				b.cmp[s] = 3'h7;
			end
		end
		return b;
	endfunction
	function automatic logic [4:0] corr(input vbsf_pkg::vbsf_branch_t b, input int p);
		logic [4:0] sum;
		sum = 5'h00;
		for (int s = 0; s < 3; s++) sum = sum + 5'(p[2 - s] ? b.tru[s] : b.cmp[s]);
		return sum;
	endfunction
	// Search run: thresholds, first move inverts, inhibit span, slip blanking
	task automatic sync_run(input logic [31:0] ctl, input int thr, input bit full);
		logic [31:0] v;
		int b0;
		do_reset();
		wr(vbsf_pkg::ADDR_CTRL, ctl);
		unanimous <= 1'b0;
		run <= 1'b1;
		b0 = n_br;
		wait_hi(0, 3000);
		chk(32'(n_br - b0 inside {[thr - 1:thr + 3]}), 32'h1);
		chk(proc_inhibit, 1'b1);
		b0 = n_br;
		@(posedge core_clk);
		#1 chk(dec_reset, 1'b0);
		repeat (200) begin
			@(posedge core_clk);
			#1;
			if (proc_inhibit === 1'b0) break;
		end
		@(posedge core_clk);
		#1 chk(32'(n_br - b0 inside {[3:4]}), 32'h1);
		rd(vbsf_pkg::ADDR_STAT, v);
		chk(v[vbsf_pkg::STAT_INV_BIT], 1'b1);
		if (full) begin
			max_iv = 0;
			wait_hi(0, 3000);
			// The stretched branch ends about 16 cycles after the slip move
			repeat (24) @(posedge core_clk);
			chk(max_iv, 16);
		end
	endtask
	initial begin
		logic [31:0] v;
		int t0;
		do_reset();
		rd(vbsf_pkg::ADDR_CTRL, v);
		chk(v, vbsf_pkg::CTRL_RESET);
		@(posedge core_clk);
		#1 chk(reg_rdata, 32'h0000_0000);
		rd(8'h08, v);
		chk(v, 32'h0000_0000);
		wr(vbsf_pkg::ADDR_STAT, 32'hffff_ffff);
		rd(vbsf_pkg::ADDR_STAT, v);
		chk(v, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			wr(vbsf_pkg::ADDR_CTRL, 32'(k * 2 + 1));
			#1 chk(tap_depth, dep[k]);
		end
		// Data path at rate 1/3 with 3-bit and 2-bit, and at rate 1/2 with 1-bit quantization
		for (int c = 0; c < 3; c++) begin
			do_reset();
			for (int s = 0; s < 3; s++) seq[s] = tab_s[c][8 - 3 * s -: 3];
			div = tab_c[c][0] ? 3 : 2;
			wr(vbsf_pkg::ADDR_CTRL, tab_c[c]);
			run <= 1'b1;
			repeat (div * 32) @(posedge core_clk);
			#1 exp_b = mk(tab_c[c][4:3], tab_c[c][0]);
			chk(branch_out, exp_b);
			chk(last_iv, div * 4);
			for (int p = 0; p < 8; p++) chk(incr_corr[p], corr(exp_b, p));
		end
		div = 3;
		sync_run(32'h0000_0007, 60, 1'b1);
		sync_run(32'h0000_0001, 30, 1'b0);
		// Clean window locks, then two excesses are needed to move
		do_reset();
		unanimous <= 1'b1;
		run <= 1'b1;
		t0 = n_br;
		wait_hi(1, 5000);
		chk(32'(n_br - t0 inside {[254:258]}), 32'h1);
		rd(vbsf_pkg::ADDR_STAT, v);
		chk(v[vbsf_pkg::STAT_LOCK_BIT], 1'b1);
		unanimous <= 1'b0;
		t0 = n_br;
		wait_hi(0, 4000);
		chk(32'(n_br - t0 inside {[119:126]}), 32'h1);
		// Rescale: delayed subtract, retrigger held off meanwhile
		do_reset();
		unanimous <= 1'b1;
		max_over <= 1'b1;
		run <= 1'b1;
		wait_hi(2, 200);
		t0 = bit_count;
		chk(32'(t0 inside {[6:7]}), 32'h1);
		@(posedge core_clk);
		wait_hi(2, 200);
		chk(32'(bit_count - t0), 32'h6);
		max_over <= 1'b0;
		close_out();
	end
	// Watchdog against a hang
	initial begin
		#500_000;
		n_errors++;
		close_out();
	end
endmodule
`default_nettype wire

// ==== vbsf_bitsync_model.sv ====
// Upstream bit synchronizer model: bit clock and quantized samples
`timescale 1ns/1ps
`default_nettype none
module vbsf_bitsync_model (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [2:0] pat_data,
	output logic bit_clk,
	output logic [2:0] sample_in,
	output logic [15:0] bit_count
);
	logic [1:0] phase_r;
	// Four core cycles per bit; sample settles two cycles before the rising edge
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_r <= 2'h0;
			bit_clk <= 1'b0;
			sample_in <= 3'h5;
		end else if (!run) begin
			phase_r <= 2'h0;
			bit_clk <= 1'b0;
			sample_in <= ~sample_in; // Idle line toggles so a stale value never passes
		end else begin
			phase_r <= phase_r + 2'h1;
			if (phase_r == 2'h0) begin
				sample_in <= pat_data;
				bit_clk <= 1'b0;
			end
			if (phase_r == 2'h2) begin
				bit_clk <= 1'b1;
			end
		end
	end
	// Bits launched, so the bench can choose the next sample
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bit_count <= 16'h0000;
		end else if (run && phase_r == 2'h3) begin
			bit_count <= bit_count + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ==== vbsf_front_end.sv ====
// Branch synchronizer, clock divider, input register, correlations and rescale control
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vbsf_front_end (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic bit_clk,
	input wire logic [2:0] sample_in,
	input wire logic unanimous,
	input wire logic max_over,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [5:0] tap_depth,
	output logic branch_clk,
	output vbsf_pkg::vbsf_branch_t branch_out,
	output logic [vbsf_pkg::NUM_PAT-1:0][4:0] incr_corr,
	output logic proc_inhibit,
	output logic dec_reset,
	output logic rescale_sub,
	output logic sync_locked
);
	// Correlation term pick per pattern bit: sample when bit is 1, complement when 0
	function automatic logic [2:0] pick(input logic pbit, input logic [2:0] t, input logic [2:0] c);
		pick = pbit ? t : c;
	endfunction

	// Mask of unused bits for one sample slot
	function automatic logic [2:0] unused_mask(input int slot, input vbsf_pkg::vbsf_ctrl_t c);
		logic [2:0] m;
		m = 3'h0;
		if (slot == vbsf_pkg::NUM_SLOT - 1 && !c.rate_third) begin
			m = vbsf_pkg::ALL_ONES3;
		end else if (c.quant_sel == 2'h1) begin
			m = 3'h1;
		end else if (c.quant_sel[1]) begin
			m = 3'h3;
		end
		unused_mask = m;
	endfunction

	vbsf_pkg::vbsf_ctrl_t ctrl_r;
	vbsf_pkg::vbsf_sync_t state_r;
	logic bit_clk_d_r;
	logic bit_tick;
	logic blank_r;
	logic div_tick;
	logic [1:0] div_cnt_r;
	logic [1:0] div_last;
	logic branch_tick;
	logic [1:0][2:0] fmt_r;
	logic [2:0] remapped;
	logic inv_r;
	logic try_slip_r;
	logic strike_r;
	logic [7:0] branch_cnt_r;
	logic [7:0] dis_cnt_r;
	logic [7:0] thr;
	logic exceed;
	logic window_end;
	logic move;
	logic [1:0] inh_cnt_r;
	logic [vbsf_pkg::NUM_PAT-1:0][3:0] part_r;
	logic [vbsf_pkg::NUM_PAT-1:0][2:0] r3_r;
	logic [2:0] resc_cnt_r;
	logic resc_start;

	// Bit clock is sampled as a synchronous level; a rising edge marks one bit time
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bit_clk_d_r <= 1'b0;
		end else begin
			bit_clk_d_r <= bit_clk;
		end
	end
	assign bit_tick = bit_clk & ~bit_clk_d_r;

	// Software switches: rate, constraint length, quantization
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_r <= vbsf_pkg::vbsf_ctrl_t'(vbsf_pkg::CTRL_RESET[4:0]);
		end else if (reg_wr && reg_addr == vbsf_pkg::ADDR_CTRL) begin
			ctrl_r.rate_third <= reg_wdata[vbsf_pkg::CTRL_RATE_BIT];
			ctrl_r.k_sel <= reg_wdata[vbsf_pkg::CTRL_K_LSB +: 2];
			ctrl_r.quant_sel <= reg_wdata[vbsf_pkg::CTRL_Q_LSB +: 2];
		end
	end

	// Read data stand the cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= 32'h0000_0000;
			if (reg_rd && reg_addr == vbsf_pkg::ADDR_CTRL) begin
				reg_rdata[vbsf_pkg::CTRL_RATE_BIT] <= ctrl_r.rate_third;
				reg_rdata[vbsf_pkg::CTRL_K_LSB +: 2] <= ctrl_r.k_sel;
				reg_rdata[vbsf_pkg::CTRL_Q_LSB +: 2] <= ctrl_r.quant_sel;
			end else if (reg_rd && reg_addr == vbsf_pkg::ADDR_STAT) begin
				reg_rdata[vbsf_pkg::STAT_LOCK_BIT] <= (state_r == vbsf_pkg::SYNC_LOCK);
				reg_rdata[vbsf_pkg::STAT_INV_BIT] <= inv_r;
				reg_rdata[vbsf_pkg::STAT_INH_BIT] <= proc_inhibit;
				reg_rdata[vbsf_pkg::STAT_RESC_BIT] <= (resc_cnt_r != 3'h0);
				reg_rdata[vbsf_pkg::STAT_DIS_LSB +: 8] <= dis_cnt_r;
			end
		end
	end

	// Unanimity depth follows the constraint length switch
	always_comb begin
		unique case (ctrl_r.k_sel)
			2'h0: tap_depth = vbsf_pkg::DEPTH_K3;
			2'h1: tap_depth = vbsf_pkg::DEPTH_K4;
			2'h2: tap_depth = vbsf_pkg::DEPTH_K5;
			2'h3: tap_depth = vbsf_pkg::DEPTH_K6;
		endcase
	end

	// Blanking swallows exactly one bit tick, which slips the branch phase by one
	always_ff @(posedge core_clk) begin
		if (srst) begin
			blank_r <= 1'b0;
		end else if (move && try_slip_r) begin
			blank_r <= 1'b1;
		end else if (bit_tick) begin
			blank_r <= 1'b0;
		end
	end
	assign div_tick = bit_tick & ~blank_r;

	// Branch clock divider: 3 at rate 1/3, 2 at rate 1/2
	assign div_last = (ctrl_r.rate_third ? vbsf_pkg::DIV_THIRD : vbsf_pkg::DIV_HALF) - 2'h1;
	assign branch_tick = div_tick && div_cnt_r == div_last;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			div_cnt_r <= 2'h0;
		end else if (div_tick) begin
			div_cnt_r <= branch_tick ? 2'h0 : div_cnt_r + 2'h1;
		end else if (div_cnt_r > div_last) begin
			div_cnt_r <= 2'h0; // Rate switch changed mid-branch
		end
	end
	// Branch clock high in the first bit time of the branch: half of it at rate 1/2, a third at rate 1/3
	assign branch_clk = (div_cnt_r == 2'h0);

	// Sign-magnitude to monotonic: zeros count down in magnitude, ones count up
	assign remapped = sample_in[2] ? sample_in : {1'b0, ~sample_in[1:0]};

	// Formatting stage keeps earlier samples of the branch
	always_ff @(posedge core_clk) begin
		if (srst) begin
			fmt_r <= '0;
		end else if (div_tick && !branch_tick) begin
			fmt_r[div_cnt_r[0]] <= remapped;
		end
	end

	// Input register: nine bits move in at once, inverted at its inputs; unused bits forced high
	always_ff @(posedge core_clk) begin
		if (srst || dec_reset) begin
			branch_out <= '0;
		end else if (branch_tick) begin
			for (int s = 0; s < vbsf_pkg::NUM_SLOT; s++) begin
				logic [2:0] v;
				v = (s == int'(div_last)) ? remapped : fmt_r[s[0]];
				v = v ^ {3{inv_r}};
				branch_out.tru[s] <= v | unused_mask(s, ctrl_r);
				branch_out.cmp[s] <= ~v | unused_mask(s, ctrl_r);
			end
		end
	end

	// First adder rank: plus per pattern, carried alongside
	always_ff @(posedge core_clk) begin
		if (srst || dec_reset) begin
			part_r <= '0;
			r3_r <= '0;
		end else if (branch_tick) begin
			for (int p = 0; p < vbsf_pkg::NUM_PAT; p++) begin
				part_r[p] <= {1'b0, pick(p[2], branch_out.tru[0], branch_out.cmp[0])}
					+ {1'b0, pick(p[1], branch_out.tru[1], branch_out.cmp[1])};
				r3_r[p] <= pick(p[0], branch_out.tru[2], branch_out.cmp[2]);
			end
		end
	end

	// Second rank: finished incremental correlations one branch later
	always_ff @(posedge core_clk) begin
		if (srst || dec_reset) begin
			incr_corr <= '0;
		end else if (branch_tick) begin
			for (int p = 0; p < vbsf_pkg::NUM_PAT; p++) begin
				incr_corr[p] <= {1'b0, part_r[p]} + {2'b00, r3_r[p]};
			end
		end
	end

	// Threshold, window end and position move
	assign thr = ctrl_r.k_sel[1] ? vbsf_pkg::THR_LONG : vbsf_pkg::THR_SHORT;
	assign exceed = dis_cnt_r > thr;
	assign window_end = branch_tick && branch_cnt_r == vbsf_pkg::WINDOW_LEN;
	// Lock moves on the second excess only
	assign move = exceed && (state_r == vbsf_pkg::SYNC_SEARCH || strike_r);

	// Branch-time and disagreement counters; inhibited branches are not judged
	always_ff @(posedge core_clk) begin
		if (srst || move || window_end || exceed) begin
			branch_cnt_r <= 8'h00;
			dis_cnt_r <= 8'h00;
		end else if (branch_tick && !proc_inhibit) begin
			branch_cnt_r <= branch_cnt_r + 8'h01;
			dis_cnt_r <= dis_cnt_r + {7'h00, ~unanimous};
		end
	end

	// Search and lock modes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= vbsf_pkg::SYNC_SEARCH;
			strike_r <= 1'b0;
		end else if (move) begin
			state_r <= vbsf_pkg::SYNC_SEARCH;
			strike_r <= 1'b0;
		end else if (exceed) begin
			strike_r <= 1'b1;
		end else if (window_end && state_r == vbsf_pkg::SYNC_SEARCH) begin
			state_r <= vbsf_pkg::SYNC_LOCK;
		end
	end
	assign sync_locked = (state_r == vbsf_pkg::SYNC_LOCK);

	// Alternate inversion and slip; slips wrap with the divider, so 2-bit slips need rate 1/3
	always_ff @(posedge core_clk) begin
		if (srst) begin
			inv_r <= 1'b0;
			try_slip_r <= 1'b0;
		end else if (move) begin
			try_slip_r <= ~try_slip_r;
			if (!try_slip_r) begin
				inv_r <= ~inv_r;
			end
		end
	end

	// Inhibit for three branch times and a one-cycle decoder reset on each move
	always_ff @(posedge core_clk) begin
		if (srst) begin
			inh_cnt_r <= 2'h0;
			dec_reset <= 1'b0;
		end else begin
			dec_reset <= move;
			if (move) begin
				inh_cnt_r <= vbsf_pkg::INHIBIT_LEN;
			end else if (branch_tick && inh_cnt_r != 2'h0) begin
				inh_cnt_r <= inh_cnt_r - 2'h1;
			end
		end
	end
	assign proc_inhibit = (inh_cnt_r != 2'h0);

	// Rescale: threshold ignored while the delay runs, so one overflow gives one subtract
	assign resc_start = bit_tick && max_over && resc_cnt_r <= vbsf_pkg::RESCALE_ARM;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resc_cnt_r <= 3'h0;
			rescale_sub <= 1'b0;
		end else begin
			rescale_sub <= bit_tick && resc_cnt_r == vbsf_pkg::RESCALE_ARM;
			if (resc_start) begin
				resc_cnt_r <= vbsf_pkg::RESCALE_DELAY;
			end else if (bit_tick && resc_cnt_r != 3'h0) begin
				resc_cnt_r <= resc_cnt_r - 3'h1;
			end
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	// Helper: cycles since rescale detection counted in bit ticks
	logic [2:0] resc_ticks_r;
	always_ff @(posedge core_clk) begin
		if (srst || resc_start) begin
			resc_ticks_r <= 3'h0;
		end else if (bit_tick && resc_ticks_r != 3'h7) begin
			resc_ticks_r <= resc_ticks_r + 3'h1;
		end
	end

	sequence s_move;
		move ##1 dec_reset;
	endsequence

	a_corr_range: assert property (incr_corr[0] <= vbsf_pkg::CORR_MAX && incr_corr[7] <= vbsf_pkg::CORR_MAX)
		else $error("Incremental correlation above 21");
	a_move_reset: assert property (move |-> s_move ##0 proc_inhibit)
		else $error("Move without reset and inhibit");
	a_inhibit_len: assert property ($rose(proc_inhibit) && !branch_tick
		|-> inh_cnt_r == vbsf_pkg::INHIBIT_LEN)
		else $error("Inhibit not three branch times");
	a_blank_once: assert property (blank_r && bit_tick && !move |=> !blank_r)
		else $error("Blanking longer than one bit time");
	a_div_range: assert property (div_tick |-> div_cnt_r <= div_last)
		else $error("Divider count out of range");
	a_lock_entry: assert property (state_r == vbsf_pkg::SYNC_SEARCH && window_end && !exceed
		|=> state_r == vbsf_pkg::SYNC_LOCK)
		else $error("Window without excess did not lock");
	a_lock_twice: assert property (state_r == vbsf_pkg::SYNC_LOCK && exceed && !strike_r
		|=> state_r == vbsf_pkg::SYNC_LOCK && strike_r && !dec_reset)
		else $error("Lock left on first excess");
	a_search_alt: assert property (move && state_r == vbsf_pkg::SYNC_SEARCH
		|=> try_slip_r != $past(try_slip_r))
		else $error("Attempts do not alternate");
	a_resc_delay: assert property (rescale_sub
		|-> $past(resc_ticks_r) == vbsf_pkg::RESCALE_DELAY - 3'h1)
		else $error("Subtract not six bit times after detection");
	a_resc_ignore: assert property (resc_start |=> !resc_start [*2])
		else $error("Rescale retriggered too soon");
	a_unused_ones: assert property (!ctrl_r.rate_third && $past(branch_tick) && !$past(dec_reset)
		&& !$past(ctrl_r.rate_third) |-> branch_out.tru[2] == 3'h7 && branch_out.cmp[2] == 3'h7)
		else $error("Unused slot not forced high");
	a_counters_restart: assert property (window_end |=> branch_cnt_r == 8'h00)
		else $error("Counters not restarted at window end");
endmodule
`default_nettype wire

// ==== vbsf_pkg.sv ====
// Package with constants and carrier types for the Viterbi branch sync front end
package vbsf_pkg;
	// Register map, byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	// Control field positions
	localparam int CTRL_RATE_BIT = 0;
	localparam int CTRL_K_LSB = 1;
	localparam int CTRL_Q_LSB = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
	// Status field positions
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_INV_BIT = 1;
	localparam int STAT_INH_BIT = 2;
	localparam int STAT_RESC_BIT = 3;
	localparam int STAT_DIS_LSB = 8;
	// Divider ratios in bit times per branch
	localparam logic [1:0] DIV_THIRD = 2'h3;
	localparam logic [1:0] DIV_HALF = 2'h2;
	// Unanimity test depths for k = 3, 4, 5, 6
	localparam logic [5:0] DEPTH_K3 = 6'h10;
	localparam logic [5:0] DEPTH_K4 = 6'h16;
	localparam logic [5:0] DEPTH_K5 = 6'h1b;
	localparam logic [5:0] DEPTH_K6 = 6'h20;
	// Disagreement thresholds
	localparam logic [7:0] THR_LONG = 8'h3c;
	localparam logic [7:0] THR_SHORT = 8'h1e;
	// Observation window in counted times
	localparam logic [7:0] WINDOW_LEN = 8'hff;
	// Processing inhibit length in branch times
	localparam logic [1:0] INHIBIT_LEN = 2'h3;
	// Rescale: subtract after this many bit times, threshold ignored meanwhile
	localparam logic [2:0] RESCALE_DELAY = 3'h6;
	localparam logic [2:0] RESCALE_ARM = 3'h1;
	// Largest correlation of three 3-bit samples
	localparam logic [4:0] CORR_MAX = 5'h15;
	localparam logic [2:0] ALL_ONES3 = 3'h7;
	localparam int NUM_PAT = 8;
	localparam int NUM_SLOT = 3;

	// Switch settings
	typedef struct packed {
		logic [1:0] quant_sel; // 0: 3-bit, 1: 2-bit, 2 or 3: 1-bit
		logic [1:0] k_sel;     // 0..3 for constraint length 3..6
		logic rate_third;      // 1: rate 1/3, 0: rate 1/2
	} vbsf_ctrl_t;

	// One branch: true and complement of each sample
	typedef struct packed {
		logic [NUM_SLOT-1:0][2:0] tru;
		logic [NUM_SLOT-1:0][2:0] cmp;
	} vbsf_branch_t;

	typedef enum logic {SYNC_SEARCH, SYNC_LOCK} vbsf_sync_t;
endpackage
